// ==== common/dfpr_consts.vh ====
`ifndef DFPR_CONSTS_VH
`define DFPR_CONSTS_VH

// Timebase
`define DFPR_CLK_HZ 10000000
`define DFPR_TICK_MS 100
`define DFPR_TICK_CYCLES (`DFPR_CLK_HZ / 1000 * `DFPR_TICK_MS)
`define DFPR_TICKS_PER_S (1000 / `DFPR_TICK_MS)
`define DFPR_OH_DELAY_S 10
`define DFPR_CLEAR_S 600
`define DFPR_TMR_W 13

// Register byte offsets
`define DFPR_REG_CTRL 8'h00
`define DFPR_REG_UV_TRIG 8'h04
`define DFPR_REG_UV_PAUSE 8'h08
`define DFPR_REG_UV_RECOV 8'h0c
`define DFPR_REG_OH_THR 8'h10
`define DFPR_REG_SENSOR 8'h14
`define DFPR_REG_DEV_LEVEL 8'h18
`define DFPR_REG_DEV_TIME 8'h1c
`define DFPR_REG_AR_LIMIT 8'h20
`define DFPR_REG_AR_INTERVAL 8'h24
`define DFPR_REG_STATUS 8'h28
`define DFPR_REG_CODES 8'h2c
`define DFPR_REG_SNAP_BASE 8'h30
`define DFPR_SNAP_STRIDE 8'h20
`define DFPR_SNAP_END 8'h90
`define DFPR_REG_SERIAL 8'h90
`define DFPR_REG_SW_VER 8'h94
`define DFPR_REG_RATED_KW 8'h98
`define DFPR_REG_RATED_V 8'h9c
`define DFPR_REG_RATED_A 8'ha0

// Control bits
`define DFPR_CTRL_UVSTALL 0
`define DFPR_CTRL_STOAUTO 1
`define DFPR_CTRL_MANRST 2

// Reset values and ranges
`define DFPR_RST_CTRL 3'h2
`define DFPR_RST_UV_TRIG 10'h1cc
`define DFPR_MIN_UV_TRIG 10'h190
`define DFPR_MAX_UV_TRIG 10'h1cc
`define DFPR_RST_UV_PAUSE 10'h1e5
`define DFPR_MIN_UV_PAUSE 10'h1cc
`define DFPR_MAX_UV_PAUSE 10'h1f4
`define DFPR_RST_UV_RECOV 10'h014
`define DFPR_MAX_UV_RECOV 10'h3e8
`define DFPR_RST_OH_THR 8'h78
`define DFPR_MAX_OH_THR 8'hc8
`define DFPR_RST_SENSOR 8'h00
`define DFPR_MAX_SENSOR_ONES 4'h3
`define DFPR_MAX_SENSOR_TENS 4'h1
`define DFPR_SENSOR_NONE 4'h0
`define DFPR_SENSOR_PT100 4'h3
`define DFPR_RST_DEV_LEVEL 10'h000
`define DFPR_MAX_DEV_LEVEL 10'h1f4
`define DFPR_DEV_LEVEL_FULL 32'h3e8
`define DFPR_RST_DEV_TIME 10'h00a
`define DFPR_MAX_DEV_TIME 10'h064
`define DFPR_RST_AR_LIMIT 7'h00
`define DFPR_MAX_AR_LIMIT 7'h64
`define DFPR_RST_AR_INTERVAL 13'h0032
`define DFPR_MIN_AR_INTERVAL 13'h0014
`define DFPR_MAX_AR_INTERVAL 13'h1770
`define DFPR_VOLT_SCALE 16'h000a

// Fault codes
`define DFPR_FC_NONE 7'h00
`define DFPR_FC_MODULE 7'h01
`define DFPR_FC_EXTDEV 7'h02
`define DFPR_FC_GROUND 7'h03
`define DFPR_FC_UNDERV 7'h04
`define DFPR_FC_BCOMM 7'h05
`define DFPR_FC_FWMIS 7'h06
`define DFPR_FC_STO 7'h07
`define DFPR_FC_OVERHEAT 7'h08
`define DFPR_FC_SPEEDDEV 7'h09
`define DFPR_FC_MAX 7'h41
`define DFPR_NUM_SRC 10

`endif

// ==== rtl/dfpr_tick.v ====
`include "dfpr_consts.vh"
module dfpr_tick #(
    parameter DIV = `DFPR_TICK_CYCLES
) (
    input wire clk_sys,
    input wire rst,
    output reg tick
);
    reg [31:0] count;
    always @(posedge clk_sys) begin
        if (rst) begin
            count <= 32'h0;
            tick <= 1'b0;
        end else if (count >= DIV - 1) begin
            count <= 32'h0;
            tick <= 1'b1;
        end else begin
            count <= count + 32'h1;
            tick <= 1'b0;
        end
    end
endmodule

// ==== rtl/dfpr_timer.v ====
`include "dfpr_consts.vh"
module dfpr_timer #(
    parameter W = `DFPR_TMR_W
) (
    input wire clk_sys,
    input wire rst,
    input wire tick,
    input wire run,
    input wire [W-1:0] limit,
    output reg done
);
    // Counts base ticks while run holds; any drop restarts the wait
    reg [W-1:0] count;
    always @(posedge clk_sys) begin
        if (rst || !run) begin
            count <= {W{1'b0}};
            done <= 1'b0;
        end else begin
            if (tick && count < limit) begin
                count <= count + {{(W-1){1'b0}}, 1'b1};
            end
            done <= (count >= limit);
        end
    end
endmodule

// ==== rtl/dfpr_top.v ====
//Contract
// - Lower frequency when bus below trigger
// - Stop lowering after pause voltage plus delay
// - Overheat fault after ten seconds above threshold
// - Sensor type digit selects sensor, channel (channel 2 used only for PT100 with tens digit 1)
// - Speed deviation fault beyond level and time
// - Zero detection time disables deviation check
// - Attempt limit zero disables auto reset
// - Auto resets spaced by configured interval
// - Limit used up leaves manual reset only
// - Manual reset during auto clears counter
// - Fault-free run 600 s clears counter
// - Module, external, ground faults never clear
// - Undervoltage, comm, firmware faults self-clear
// - Reset interval locks output, zero frequency
// - Auto reset restarts with speed tracking
// - Keep current, latest, second fault codes
// - Snapshot measurements for each fault
// - Setting enables safe torque off auto reset
// - Identity values read only
//
// The Avalon-MM interface to the registers and the register offsets were left to the implementer.
`include "dfpr_consts.vh"
module dfpr_top #(
    parameter TICK_CYCLES = `DFPR_TICK_CYCLES,
    parameter [15:0] SERIAL_NO = 16'h0001,
    parameter [15:0] SW_VERSION = 16'h0100,
    parameter [15:0] RATED_KW = 16'h0000,
    parameter [15:0] RATED_V = 16'h0000,
    parameter [15:0] RATED_A = 16'h0000
) (
    input wire clk_sys,
    input wire rst,
    input wire [7:0] avs_address,
    input wire avs_read,
    input wire avs_write,
    input wire [31:0] avs_writedata,
    input wire [3:0] avs_byteenable,
    output reg [31:0] avs_readdata,
    output reg avs_waitrequest,
    input wire [15:0] busVoltage,
    input wire [15:0] outCurrent,
    input wire [15:0] outFrequency,
    input wire [15:0] statusWord,
    input wire [15:0] bridgeTemp,
    input wire [7:0] inputTerminals,
    input wire [3:0] outputTerminals,
    input wire [15:0] runMinutes,
    input wire [7:0] motorTempCh1,
    input wire [7:0] motorTempCh2,
    input wire [15:0] speedRef,
    input wire [15:0] speedActual,
    input wire [15:0] maxFrequency,
    input wire driveRunning,
    input wire manualResetCmd,
    input wire moduleProtect,
    input wire externalDeviceFault,
    input wire groundShortFault,
    input wire undervoltageFault,
    input wire boardCommError,
    input wire powerBoardFirmwareMismatch,
    input wire safeTorqueOff,
    output reg stallLowerFreq,
    output reg outputLock,
    output reg zeroFreqCmd,
    output reg speedTrackStart,
    output reg faultActive,
    output reg [6:0] faultCode,
    output reg motorOverheatFault,
    output reg speedErrorExcessFault
);
    localparam ST_RUN = 2'h0;
    localparam ST_FAULT = 2'h1;
    localparam ST_WAIT = 2'h2;
    localparam [12:0] OH_LIMIT = `DFPR_OH_DELAY_S * `DFPR_TICKS_PER_S + 1;
    localparam [12:0] CLEAR_LIMIT = `DFPR_CLEAR_S * `DFPR_TICKS_PER_S;

    function in_range;
        input [15:0] v;
        input [15:0] lo;
        input [15:0] hi;
        begin
            in_range = (v >= lo) && (v <= hi);
        end
    endfunction

    function [15:0] be_merge;
        input [15:0] old;
        input [31:0] wd;
        input [3:0] be;
        begin
            be_merge = {be[1] ? wd[15:8] : old[15:8], be[0] ? wd[7:0] : old[7:0]};
        end
    endfunction

    function [15:0] volts_x10;
        input [9:0] v;
        begin
            volts_x10 = {6'h00, v} * `DFPR_VOLT_SCALE;
        end
    endfunction

    function [6:0] src_code;
        input [3:0] idx;
        begin
            case (idx)
                4'h0: src_code = `DFPR_FC_MODULE;
                4'h1: src_code = `DFPR_FC_EXTDEV;
                4'h2: src_code = `DFPR_FC_GROUND;
                4'h3: src_code = `DFPR_FC_UNDERV;
                4'h4: src_code = `DFPR_FC_BCOMM;
                4'h5: src_code = `DFPR_FC_FWMIS;
                4'h6: src_code = `DFPR_FC_STO;
                4'h7: src_code = `DFPR_FC_OVERHEAT;
                4'h8: src_code = `DFPR_FC_SPEEDDEV;
                default: src_code = `DFPR_FC_NONE;
            endcase
        end
    endfunction

    reg [2:0] ctrl;
    reg [9:0] uvTrig;
    reg [9:0] uvPause;
    reg [9:0] uvRecov;
    reg [7:0] ohThr;
    reg [7:0] sensorType;
    reg [9:0] devLevel;
    reg [9:0] devTime;
    reg [6:0] arLimit;
    reg [12:0] arInterval;
    reg [1:0] state;
    reg [6:0] attempts;
    reg [3:0] faultIdx;
    reg [6:0] codeHist [0:2];
    reg [15:0] snapVolt [0:2];
    reg [15:0] snapCurr [0:2];
    reg [15:0] snapFreq [0:2];
    reg [15:0] snapStat [0:2];
    reg [15:0] snapTemp [0:2];
    reg [11:0] snapTerm [0:2];
    reg [15:0] snapRun [0:2];
    reg [31:0] next_readdata;
    reg [3:0] pickIdx;
    integer i;
    integer j;

    wire tick;
    wire recovDone;
    wire ohDone;
    wire devDone;
    wire intervalDone;
    wire clearDone;
    wire busAccess = avs_read || avs_write;
    wire doWrite = avs_write && !avs_waitrequest;
    wire [7:0] wordAddr = {avs_address[7:2], 2'b00};
    wire [15:0] wd = be_merge(16'h0000, avs_writedata, avs_byteenable);
    wire manualReset = manualResetCmd || (doWrite && wordAddr == `DFPR_REG_CTRL && wd[`DFPR_CTRL_MANRST]);

    dfpr_tick #(.DIV(TICK_CYCLES)) u_tick (
        .clk_sys(clk_sys),
        .rst(rst),
        .tick(tick)
    );

    // Undervoltage stall
    wire busBelowTrig = busVoltage < volts_x10(uvTrig);
    wire busAbovePause = busVoltage > volts_x10(uvPause);
    dfpr_timer u_recov (
        .clk_sys(clk_sys),
        .rst(rst),
        .tick(tick),
        .run(stallLowerFreq && busAbovePause),
        .limit({3'h0, uvRecov}),
        .done(recovDone)
    );

    // Motor temperature selection
    wire [3:0] sensorOnes = sensorType[3:0];
    wire [3:0] sensorTens = sensorType[7:4];
    wire useCh2 = (sensorOnes == `DFPR_SENSOR_PT100) && (sensorTens == `DFPR_MAX_SENSOR_TENS);
    wire [7:0] motorTemp = useCh2 ? motorTempCh2 : motorTempCh1;
    wire ohCond = (sensorOnes != `DFPR_SENSOR_NONE) && (motorTemp > ohThr);
    dfpr_timer u_oh (
        .clk_sys(clk_sys),
        .rst(rst),
        .tick(tick),
        .run(ohCond),
        .limit(OH_LIMIT),
        .done(ohDone)
    );

    // Speed deviation: |ref - act| * 1000 > level * fmax, level in 0.1 %
    wire [15:0] speedDiff = (speedRef >= speedActual) ? speedRef - speedActual : speedActual - speedRef;
    wire [31:0] diffScaled = {16'h0000, speedDiff} * `DFPR_DEV_LEVEL_FULL;
    wire [31:0] devBound = {22'h0, devLevel} * {16'h0000, maxFrequency};
    wire devCond = (devTime != 10'h000) && (diffScaled > devBound);
    dfpr_timer u_dev (
        .clk_sys(clk_sys),
        .rst(rst),
        .tick(tick),
        .run(devCond),
        .limit({3'h0, devTime} + 13'h0001),
        .done(devDone)
    );

    dfpr_timer u_interval (
        .clk_sys(clk_sys),
        .rst(rst),
        .tick(tick),
        .run(state == ST_WAIT),
        .limit(arInterval),
        .done(intervalDone)
    );

    dfpr_timer u_clear (
        .clk_sys(clk_sys),
        .rst(rst),
        .tick(tick),
        .run(state == ST_RUN && driveRunning),
        .limit(CLEAR_LIMIT),
        .done(clearDone)
    );

    wire [`DFPR_NUM_SRC-1:0] srcVec = {1'b0, speedErrorExcessFault, motorOverheatFault, safeTorqueOff,
        powerBoardFirmwareMismatch, boardCommError, undervoltageFault, groundShortFault,
        externalDeviceFault, moduleProtect};

    // Lowest index wins, so never-clearing faults are recorded first
    always @* begin
        pickIdx = 4'hf;
        for (j = `DFPR_NUM_SRC - 1; j >= 0; j = j - 1) begin
            if (srcVec[j]) begin
                pickIdx = j[3:0];
            end
        end
    end

    wire permanent = (faultIdx <= 4'h2);
    wire selfClear = (faultIdx >= 4'h3) && (faultIdx <= 4'h5);
    wire autoAllowed = (arLimit != 7'h00) && (attempts < arLimit) &&
        (faultIdx != 4'h6 || ctrl[`DFPR_CTRL_STOAUTO]);

    always @(posedge clk_sys) begin
        if (rst) begin
            stallLowerFreq <= 1'b0;
            motorOverheatFault <= 1'b0;
            speedErrorExcessFault <= 1'b0;
        end else begin
            if (ctrl[`DFPR_CTRL_UVSTALL] && busBelowTrig) begin
                stallLowerFreq <= 1'b1;
            end else if (recovDone || !ctrl[`DFPR_CTRL_UVSTALL]) begin
                stallLowerFreq <= 1'b0;
            end
            motorOverheatFault <= ohDone;
            speedErrorExcessFault <= devDone;
        end
    end

    // Fault manager
    always @(posedge clk_sys) begin
        if (rst) begin
            state <= ST_RUN;
            attempts <= 7'h00;
            faultIdx <= 4'hf;
            speedTrackStart <= 1'b0;
            for (i = 0; i < 3; i = i + 1) begin
                codeHist[i] <= `DFPR_FC_NONE;
                snapVolt[i] <= 16'h0000;
                snapCurr[i] <= 16'h0000;
                snapFreq[i] <= 16'h0000;
                snapStat[i] <= 16'h0000;
                snapTemp[i] <= 16'h0000;
                snapTerm[i] <= 12'h000;
                snapRun[i] <= 16'h0000;
            end
        end else begin
            speedTrackStart <= 1'b0;
            case (state)
                ST_RUN: begin
                    if (pickIdx != 4'hf) begin
                        state <= ST_FAULT;
                        faultIdx <= pickIdx;
                        for (i = 2; i > 0; i = i - 1) begin
                            codeHist[i] <= codeHist[i-1];
                            snapVolt[i] <= snapVolt[i-1];
                            snapCurr[i] <= snapCurr[i-1];
                            snapFreq[i] <= snapFreq[i-1];
                            snapStat[i] <= snapStat[i-1];
                            snapTemp[i] <= snapTemp[i-1];
                            snapTerm[i] <= snapTerm[i-1];
                            snapRun[i] <= snapRun[i-1];
                        end
                        codeHist[0] <= src_code(pickIdx);
                        snapVolt[0] <= busVoltage;
                        snapCurr[0] <= outCurrent;
                        snapFreq[0] <= outFrequency;
                        snapStat[0] <= statusWord;
                        snapTemp[0] <= bridgeTemp;
                        snapTerm[0] <= {outputTerminals, inputTerminals};
                        snapRun[0] <= runMinutes;
                    end else if (clearDone) begin
                        attempts <= 7'h00;
                    end
                end
                ST_FAULT: begin
                    if (permanent) begin
                        state <= ST_FAULT;
                    end else if (selfClear) begin
                        if (!srcVec[faultIdx]) begin
                            state <= ST_RUN;
                        end
                    end else if (manualReset) begin
                        state <= ST_RUN;
                    end else if (autoAllowed) begin
                        state <= ST_WAIT;
                    end
                end
                ST_WAIT: begin
                    if (manualReset) begin
                        attempts <= 7'h00;
                        state <= ST_RUN;
                    end else if (intervalDone) begin
                        attempts <= attempts + 7'h01;
                        state <= ST_RUN;
                        speedTrackStart <= 1'b1;
                    end
                end
                default: begin
                    state <= ST_RUN;
                end
            endcase
        end
    end

    always @(posedge clk_sys) begin
        if (rst) begin
            outputLock <= 1'b0;
            zeroFreqCmd <= 1'b0;
            faultActive <= 1'b0;
            faultCode <= `DFPR_FC_NONE;
        end else begin
            outputLock <= (state != ST_RUN);
            zeroFreqCmd <= (state != ST_RUN);
            faultActive <= (state != ST_RUN);
            faultCode <= (state != ST_RUN) ? codeHist[0] : `DFPR_FC_NONE;
        end
    end

    // Configuration writes outside the legal range are ignored
    always @(posedge clk_sys) begin
        if (rst) begin
            ctrl <= `DFPR_RST_CTRL;
            uvTrig <= `DFPR_RST_UV_TRIG;
            uvPause <= `DFPR_RST_UV_PAUSE;
            uvRecov <= `DFPR_RST_UV_RECOV;
            ohThr <= `DFPR_RST_OH_THR;
            sensorType <= `DFPR_RST_SENSOR;
            devLevel <= `DFPR_RST_DEV_LEVEL;
            devTime <= `DFPR_RST_DEV_TIME;
            arLimit <= `DFPR_RST_AR_LIMIT;
            arInterval <= `DFPR_RST_AR_INTERVAL;
        end else if (doWrite) begin
            case (wordAddr)
                `DFPR_REG_CTRL: ctrl <= {1'b0, avs_byteenable[0] ? wd[1:0] : ctrl[1:0]};
                `DFPR_REG_UV_TRIG: begin
                    if (in_range(wd, {6'h0, `DFPR_MIN_UV_TRIG}, {6'h0, `DFPR_MAX_UV_TRIG})) begin
                        uvTrig <= wd[9:0];
                    end
                end
                `DFPR_REG_UV_PAUSE: begin
                    if (in_range(wd, {6'h0, `DFPR_MIN_UV_PAUSE}, {6'h0, `DFPR_MAX_UV_PAUSE})) begin
                        uvPause <= wd[9:0];
                    end
                end
                `DFPR_REG_UV_RECOV: begin
                    if (in_range(wd, 16'h0000, {6'h0, `DFPR_MAX_UV_RECOV})) begin
                        uvRecov <= wd[9:0];
                    end
                end
                `DFPR_REG_OH_THR: begin
                    if (in_range(wd, 16'h0000, {8'h0, `DFPR_MAX_OH_THR})) begin
                        ohThr <= wd[7:0];
                    end
                end
                `DFPR_REG_SENSOR: begin
                    if (wd[15:8] == 8'h00 && wd[3:0] <= `DFPR_MAX_SENSOR_ONES && wd[7:4] <= `DFPR_MAX_SENSOR_TENS) begin
                        sensorType <= wd[7:0];
                    end
                end
                `DFPR_REG_DEV_LEVEL: begin
                    if (in_range(wd, 16'h0000, {6'h0, `DFPR_MAX_DEV_LEVEL})) begin
                        devLevel <= wd[9:0];
                    end
                end
                `DFPR_REG_DEV_TIME: begin
                    if (in_range(wd, 16'h0000, {6'h0, `DFPR_MAX_DEV_TIME})) begin
                        devTime <= wd[9:0];
                    end
                end
                `DFPR_REG_AR_LIMIT: begin
                    if (in_range(wd, 16'h0000, {9'h0, `DFPR_MAX_AR_LIMIT})) begin
                        arLimit <= wd[6:0];
                    end
                end
                `DFPR_REG_AR_INTERVAL: begin
                    if (in_range(wd, {3'h0, `DFPR_MIN_AR_INTERVAL}, {3'h0, `DFPR_MAX_AR_INTERVAL})) begin
                        arInterval <= wd[12:0];
                    end
                end
                default: begin
                    ctrl <= ctrl;
                end
            endcase
        end
    end

    // Read mux; snapshot block is three entries of eight words
    wire [7:0] snapOff = wordAddr - `DFPR_REG_SNAP_BASE;
    wire [1:0] snapEnt = snapOff[6:5];
    always @* begin
        next_readdata = 32'h0000_0000;
        if (wordAddr >= `DFPR_REG_SNAP_BASE && wordAddr < `DFPR_SNAP_END) begin
            case (snapOff[4:2])
                3'h0: next_readdata = {16'h0000, snapVolt[snapEnt]};
                3'h1: next_readdata = {16'h0000, snapCurr[snapEnt]};
                3'h2: next_readdata = {16'h0000, snapFreq[snapEnt]};
                3'h3: next_readdata = {16'h0000, snapStat[snapEnt]};
                3'h4: next_readdata = {16'h0000, snapTemp[snapEnt]};
                3'h5: next_readdata = {20'h00000, snapTerm[snapEnt]};
                3'h6: next_readdata = {16'h0000, snapRun[snapEnt]};
                default: next_readdata = 32'h0000_0000;
            endcase
        end else begin
            case (wordAddr)
                `DFPR_REG_CTRL: next_readdata = {30'h0, ctrl[1:0]};
                `DFPR_REG_UV_TRIG: next_readdata = {22'h0, uvTrig};
                `DFPR_REG_UV_PAUSE: next_readdata = {22'h0, uvPause};
                `DFPR_REG_UV_RECOV: next_readdata = {22'h0, uvRecov};
                `DFPR_REG_OH_THR: next_readdata = {24'h0, ohThr};
                `DFPR_REG_SENSOR: next_readdata = {24'h0, sensorType};
                `DFPR_REG_DEV_LEVEL: next_readdata = {22'h0, devLevel};
                `DFPR_REG_DEV_TIME: next_readdata = {22'h0, devTime};
                `DFPR_REG_AR_LIMIT: next_readdata = {25'h0, arLimit};
                `DFPR_REG_AR_INTERVAL: next_readdata = {19'h0, arInterval};
                `DFPR_REG_STATUS: next_readdata = {17'h0, attempts, 3'h0, permanent && faultActive,
                    !autoAllowed, state == ST_WAIT, faultActive, stallLowerFreq};
                `DFPR_REG_CODES: next_readdata = {9'h0, codeHist[2], 1'b0, codeHist[1], 1'b0, codeHist[0]};
                `DFPR_REG_SERIAL: next_readdata = {16'h0000, SERIAL_NO};
                `DFPR_REG_SW_VER: next_readdata = {16'h0000, SW_VERSION};
                `DFPR_REG_RATED_KW: next_readdata = {16'h0000, RATED_KW};
                `DFPR_REG_RATED_V: next_readdata = {16'h0000, RATED_V};
                `DFPR_REG_RATED_A: next_readdata = {16'h0000, RATED_A};
                default: next_readdata = 32'h0000_0000;
            endcase
        end
    end

    // One wait cycle per access keeps readdata registered
    always @(posedge clk_sys) begin
        if (rst) begin
            avs_waitrequest <= 1'b1;
            avs_readdata <= 32'h0000_0000;
        end else if (busAccess && avs_waitrequest) begin
            avs_waitrequest <= 1'b0;
            avs_readdata <= next_readdata;
        end else begin
            avs_waitrequest <= 1'b1;
        end
    end
endmodule

// ==== verif/dfpr_checker.sv ====
`include "dfpr_consts.vh"
module dfpr_checker #(
    parameter [15:0] SERIAL_NO = 16'h0001
) (
    input wire clk_sys,
    input wire rst,
    input wire [7:0] avs_address,
    input wire avs_read,
    input wire [31:0] avs_readdata,
    input wire avs_waitrequest,
    input wire undervoltageFault,
    input wire outputLock,
    input wire zeroFreqCmd,
    input wire speedTrackStart,
    input wire faultActive,
    input wire [6:0] faultCode
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);
    a_lock_zero:
        assert property (outputLock == zeroFreqCmd) else $error("lock and zero command differ");
    a_fault_lock:
        assert property ($rose(faultActive) |-> outputLock) else $error("fault without output lock");
    a_track_pulse:
        assert property (speedTrackStart |=> !speedTrackStart && !outputLock) else $error("bad restart pulse");
    a_perm_hold:
        assert property (faultActive && faultCode == `DFPR_FC_MODULE |=> faultActive && faultCode == `DFPR_FC_MODULE)
        else $error("permanent fault cleared");
    a_self_clear:
        assert property (faultActive && faultCode == `DFPR_FC_UNDERV && !undervoltageFault |-> ##[1:3] !faultActive)
        else $error("undervoltage fault stuck");
    a_code_idle:
        assert property (!faultActive |-> faultCode == `DFPR_FC_NONE) else $error("code without fault");
    a_code_range:
        assert property (faultCode <= `DFPR_FC_MAX) else $error("fault code out of range");
    a_ident_read:
        assert property (avs_read && !avs_waitrequest && avs_address == `DFPR_REG_SERIAL
            |-> avs_readdata == {16'h0000, SERIAL_NO}) else $error("identity read wrong");
endmodule
bind dfpr_top dfpr_checker #(.SERIAL_NO(SERIAL_NO)) chk (.*);

// ==== verif/dfpr_plant.sv ====
module dfpr_plant (
    input wire clk_sys,
    input wire [6:0] causeReq,
    input wire [15:0] voltReq,
    output logic [6:0] cause = 7'h00,
    output logic [15:0] busV = 16'h1388
);
    timeunit 1ns;
    timeprecision 1ns;
    // Levels move only at the edge, so the drive never sees a glitch
    always @(posedge clk_sys) begin
        cause <= causeReq;
        busV <= voltReq;
    end
endmodule

// ==== verif/testbench.sv ====
`include "dfpr_consts.vh"
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk_sys = 0, rst = 1, avs_read = 0, avs_write = 0, driveRunning = 0, manualResetCmd = 0;
    logic [7:0] avs_address = 0;
    logic [31:0] avs_writedata = 0, avs_readdata, rd;
    logic avs_waitrequest, stallLowerFreq, outputLock, zeroFreqCmd, speedTrackStart, faultActive;
    logic motorOverheatFault, speedErrorExcessFault;
    logic [6:0] faultCode, causeReq = 0, cause;
    logic [15:0] voltReq = 16'h1388, busV, cnt = 0;
    int mismatches = 0, checks = 0, cyc = 0, n;
    logic [39:0] rows [8] = '{{`DFPR_REG_CTRL, 32'h2}, {`DFPR_REG_UV_TRIG, 32'h1cc},
        {`DFPR_REG_UV_PAUSE, 32'h1e5}, {`DFPR_REG_UV_RECOV, 32'h14},
        {`DFPR_REG_OH_THR, 32'h78}, {`DFPR_REG_SENSOR, 32'h0},
        {`DFPR_REG_AR_LIMIT, 32'h0}, {`DFPR_REG_AR_INTERVAL, 32'h32}};
    dfpr_plant plant (.clk_sys(clk_sys), .causeReq(causeReq), .voltReq(voltReq), .cause(cause), .busV(busV));
    dfpr_top #(.TICK_CYCLES(10)) dut (.*, .avs_byteenable(4'hf), .busVoltage(busV), .outCurrent(cnt),
        .outFrequency(cnt), .statusWord(cnt), .bridgeTemp(cnt), .inputTerminals(cnt[7:0]),
        .outputTerminals(cnt[3:0]), .runMinutes(cnt), .motorTempCh1(cnt[15:8]), .motorTempCh2(cnt[7:0]),
        .speedRef(cnt), .speedActual(cnt), .maxFrequency(cnt), .moduleProtect(cause[0]),
        .externalDeviceFault(cause[1]), .groundShortFault(cause[2]), .undervoltageFault(cause[3]),
        .boardCommError(cause[4]), .powerBoardFirmwareMismatch(cause[5]), .safeTorqueOff(cause[6]));
    always #50 clk_sys = ~clk_sys;
    task automatic final_report;
        if (mismatches == 0 && checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    // Hang guard: the whole sequence needs under 3000 cycles
    always @(posedge clk_sys) begin
        cnt <= cnt + 16'h0001;
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            mismatches++;
            final_report();
        end
    end
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        checks++;
        if (s !== e) begin
            mismatches++;
            $display("CHECK FAILED %0t seen %h expected %h", $time, s, e);
        end
    endtask
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        avs_write <= w;
        avs_read <= !w;
        avs_address <= a;
        avs_writedata <= d;
        do @(posedge clk_sys); while (avs_waitrequest !== 1'b0);
        rd = avs_readdata;
        avs_write <= 0;
        avs_read <= 0;
    endtask
    task automatic fault(input logic [6:0] c);
        causeReq <= c;
        repeat (3) @(posedge clk_sys);
        causeReq <= 0;
    endtask
    initial begin
        repeat (4) @(posedge clk_sys);
        rst <= 0;
        driveRunning <= 1;
        foreach (rows[i]) begin
            bus(0, rows[i][39:32], 0);
            chk(rd, rows[i][31:0]);
        end
        bus(1, `DFPR_REG_SERIAL, 32'h55);
        bus(0, `DFPR_REG_SERIAL, 0);
        chk(rd, 32'h1);
        bus(1, `DFPR_REG_UV_TRIG, 32'h18f);
        bus(0, `DFPR_REG_UV_TRIG, 0);
        chk(rd, 32'h1cc);
        bus(1, `DFPR_REG_CTRL, 32'h3);
        voltReq <= 16'h1194;
        repeat (5) @(posedge clk_sys);
        chk(stallLowerFreq, 1);
        voltReq <= 16'h1388;
        repeat (100) @(posedge clk_sys);
        chk(stallLowerFreq, 1);
        repeat (120) @(posedge clk_sys);
        chk(stallLowerFreq, 0);
        fault(7'h01);
        manualResetCmd <= 1;
        @(posedge clk_sys);
        manualResetCmd <= 0;
        repeat (5) @(posedge clk_sys);
        chk(faultCode, 1);
        rst <= 1;
        repeat (2) @(posedge clk_sys);
        rst <= 0;
        fault(7'h08);
        @(posedge clk_sys);
        chk(faultCode, 4);
        repeat (4) @(posedge clk_sys);
        chk(faultActive, 0);
        bus(1, `DFPR_REG_AR_LIMIT, 32'h1);
        bus(1, `DFPR_REG_AR_INTERVAL, 32'h14);
        fault(7'h40);
        repeat (2) @(posedge clk_sys);
        chk({outputLock, zeroFreqCmd}, 2'b11);
        n = 0;
        while (speedTrackStart !== 1'b1) begin
            @(posedge clk_sys);
            n++;
        end
        chk(n inside {[190:215]}, 1);
        fault(7'h40);
        repeat (400) @(posedge clk_sys);
        chk(faultCode, 7);
        bus(1, `DFPR_REG_CTRL, 32'h6);
        repeat (3) @(posedge clk_sys);
        chk(faultActive, 0);
        bus(0, `DFPR_REG_CODES, 0);
        chk(rd, 32'h00040707);
        bus(0, `DFPR_REG_SNAP_BASE + 2 * `DFPR_SNAP_STRIDE, 0);
        chk(rd, 32'h1388);
        bus(0, `DFPR_REG_STATUS, 0);
        chk(rd[14:8], 1);
        bus(1, `DFPR_REG_OH_THR, 0);
        bus(1, `DFPR_REG_SENSOR, 32'h1);
        repeat (990) @(posedge clk_sys);
        chk(motorOverheatFault, 0);
        repeat (40) @(posedge clk_sys);
        chk({motorOverheatFault, faultCode}, 8'h88);
        final_report();
    end
endmodule
